/* rtl/nvm_access_map.svh */
`ifndef NVM_ACCESS_MAP_SVH
`define NVM_ACCESS_MAP_SVH
// What this block does
// - Data EEPROM has 256 bytes, low address only.
// - Program mode uses 14-bit data, 15-bit address.
// - EEPROM byte write erases, then programs automatically.
// - Program memory reads are always allowed.
// - Space select bit picks EEPROM or program; resets EEPROM.
// - Software sets read/write strobes; hardware clears them.
// - Write enable clears only at power-up.
// - Reset during a write sets the error flag except at power-up.
// - Write end clears strobe, sets done flag except after a latch-only load.
// - Unlock register always reads as zero.
// - Read data appears right after the read strobe.
// - Low data holds read value until read/written.
// - Write starts only after 55h, AAh, then strobe.
// - Write strobe blocked unless write enable already set.
// - Clearing write enable never aborts a running write.
// - No EEPROM write while the power-up timer runs.
// - Internal timer sets write duration and completion.
// - Code protection locks programmer port, not the processor.
// - Data protection active at 0; processor reads still work.
// - Program writes only outside self-write protected segments.
// - Row-only erase; writes go through 14-bit latches.
// - Rows are 32 words, latch blocks are 8 words.
// - Latches return to 3FFF after a program write.

// ****************************************************************
// Register selects and control bit positions
// ****************************************************************
`define NVM_SEL_ADDR_LOW 3'h0
`define NVM_SEL_ADDR_HIGH 3'h1
`define NVM_SEL_DATA_LOW 3'h2
`define NVM_SEL_DATA_HIGH 3'h3
`define NVM_SEL_CONTROL 3'h4
`define NVM_SEL_UNLOCK 3'h5
`define NVM_CTL_RD 0
`define NVM_CTL_WR 1
`define NVM_CTL_WRITE_ENABLE_BIT 2
`define NVM_CTL_WRITE_ERROR_FLAG 3
`define NVM_CTL_FREE 4
`define NVM_CTL_LATCH_LOAD_ONLY 5
`define NVM_CTL_CONFIG_SPACE_SELECT 6
`define NVM_CTL_PGD 7
`define NVM_CTL_RESET 8'h00

// ****************************************************************
// Values
// ****************************************************************
`define NVM_UNLOCK_KEY1 8'h55
`define NVM_UNLOCK_KEY2 8'hAA
`define NVM_ERASED_BYTE 8'hFF
`define NVM_ERASED_WORD 14'h3FFF
`define NVM_WRT_BOOT_LIMIT 15'h0200
`define NVM_WRT_HALF_LIMIT 15'h4000
`define NVM_ROW_LAST 24'h00_001F
`define NVM_LATCH_LAST 24'h00_0007

// ****************************************************************
// Timing
// ****************************************************************
`define NVM_CLK_MHZ 125
`define NVM_PWRT_MS 64
`define NVM_WRITE_MS 2
`define NVM_PWRT_CYCLES (`NVM_PWRT_MS * 1000 * `NVM_CLK_MHZ)
`define NVM_WRITE_CYCLES (`NVM_WRITE_MS * 1000 * `NVM_CLK_MHZ)
`endif

/* rtl/nvm_pkg.sv */
package nvm_pkg;
    typedef enum logic [1:0] {UL_IDLE, UL_GOT_FIRST, UL_ARMED} unlock_state_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT, ST_EE_ERASE, ST_EE_PROG, ST_PM_ROW, ST_PM_BLOCK, ST_FINISH
    } wr_state_t;
endpackage : nvm_pkg

/* rtl/nvm_array.sv */
`timescale 1ns/100ps
module nvm_array #(
    parameter int WIDTH = 8,
    parameter int AWIDTH = 8
) (
    // Clock
    input wire logic mclk_i,
    // Access
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [AWIDTH-1:0] addr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [2**AWIDTH];
    logic [WIDTH-1:0] rdata_reg;

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (re_i) begin
            rdata_reg <= mem[addr_i];
        end
    end

    assign rdata_o = rdata_reg;
endmodule : nvm_array

/* rtl/startup_timer.sv */
`timescale 1ns/100ps
module startup_timer #(
    parameter int CYCLES = 8000000
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic power_up_i,
    // Status
    output logic running_o
);
    logic [23:0] cnt_reg, cnt_next;
    logic run_reg, run_next;

    // Only a power-up reset restarts the timer; a later reset leaves it alone.
    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        if (run_reg) begin
            if (cnt_reg == 24'h00_0000) begin
                run_next = 1'b0;
            end else begin
                cnt_next = cnt_reg - 24'h00_0001;
            end
        end
        if (reset_i && power_up_i) begin
            run_next = 1'b1;
            cnt_next = 24'(CYCLES - 1);
        end
    end

    always_ff @(posedge mclk_i) begin
        cnt_reg <= cnt_next;
        run_reg <= run_next;
    end

    assign running_o = run_reg;
endmodule : startup_timer

/* rtl/eeprom_flash_access_ctrl.sv */
`timescale 1ns/100ps
`include "nvm_access_map.svh"
module eeprom_flash_access_ctrl import nvm_pkg::*; #(
    parameter int PWRT_CYCLES = `NVM_PWRT_CYCLES,
    parameter int WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic power_up_i,
    // Software register writes
    input wire logic reg_wr_i,
    input wire logic [2:0] reg_sel_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic write_done_clear_i,
    // Configuration word bits
    input wire logic [1:0] self_write_protect_i,
    input wire logic data_protect_bit_i,
    input wire logic code_protect_i,
    // Register views
    output logic [7:0] nvm_control_o,
    output logic [7:0] nvm_unlock_o,
    output logic [7:0] nvm_addr_low_o,
    output logic [7:0] nvm_addr_high_o,
    output logic [7:0] nvm_data_low_o,
    output logic [7:0] nvm_data_high_o,
    // Status
    output logic write_done_flag_o,
    output logic prog_port_data_lock_o,
    output logic prog_port_code_lock_o
);
    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0] ctl_reg, ctl_next;
    logic [7:0] addr_lo_reg, addr_lo_next;
    logic [6:0] addr_hi_reg, addr_hi_next;
    logic [7:0] data_lo_reg, data_lo_next;
    logic [5:0] data_hi_reg, data_hi_next;
    logic [7:0] unlock_rd_reg;
    logic done_reg, done_next;
    logic lock_dat_reg, lock_dat_next, lock_code_reg, lock_code_next;
    logic rd_pend_reg, rd_pend_next;
    logic op_pm_reg, op_pm_next, op_erase_reg, op_erase_next, op_quiet_reg, op_quiet_next;
    logic [23:0] cnt_reg, cnt_next;
    unlock_state_t ul_reg, ul_next;
    wr_state_t st_reg, st_next;
    logic [14:0] pm_addr;
    logic [14:0] pm_maddr;
    logic [13:0] pm_wdata, pm_q;
    logic [7:0] ee_wdata, ee_q;
    logic ee_we, pm_we, ee_re, pm_re;
    logic pm_locked, pwrt_running, start, ctl_write, latch_load, latch_clear;
    logic [13:0] latch_q [8];
    assign pm_addr = {addr_hi_reg, addr_lo_reg};
    assign ctl_write = reg_wr_i && (reg_sel_i == `NVM_SEL_CONTROL);

    // ****************************************************************
    // Self-write protection and start qualification
    // ****************************************************************
    always_comb begin
        case (self_write_protect_i)
            2'b11: pm_locked = 1'b0;
            2'b10: pm_locked = pm_addr < `NVM_WRT_BOOT_LIMIT;
            2'b01: pm_locked = pm_addr < `NVM_WRT_HALF_LIMIT;
            default: pm_locked = 1'b1;
        endcase
    end

    // The strobe is judged against the write enable already stored, so one write
    // cannot both enable and start.
    assign start = ctl_write && reg_wdata_i[`NVM_CTL_WR] && ctl_reg[`NVM_CTL_WRITE_ENABLE_BIT]
        && (ul_reg == UL_ARMED) && !pwrt_running && (st_reg == ST_IDLE);

    // ****************************************************************
    // Unlock sequence
    // ****************************************************************
    // Any other register write between the keys disarms the sequence.
    always_comb begin
        ul_next = ul_reg;
        if (reg_wr_i) begin
            if (reg_sel_i != `NVM_SEL_UNLOCK) begin
                ul_next = UL_IDLE;
            end else if (reg_wdata_i == `NVM_UNLOCK_KEY1) begin
                ul_next = UL_GOT_FIRST;
            end else if (reg_wdata_i == `NVM_UNLOCK_KEY2 && ul_reg == UL_GOT_FIRST) begin
                ul_next = UL_ARMED;
            end else begin
                ul_next = UL_IDLE;
            end
        end
        if (reset_i) begin
            ul_next = UL_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        ul_reg <= ul_next;
    end

    // ****************************************************************
    // Registers, reads and write sequencing
    // ****************************************************************
    always_comb begin
        ctl_next = ctl_reg;
        addr_lo_next = addr_lo_reg;
        addr_hi_next = addr_hi_reg;
        data_lo_next = data_lo_reg;
        data_hi_next = data_hi_reg;
        st_next = st_reg;
        cnt_next = cnt_reg;
        op_pm_next = op_pm_reg;
        op_erase_next = op_erase_reg;
        op_quiet_next = op_quiet_reg;
        lock_dat_next = !data_protect_bit_i;
        lock_code_next = !code_protect_i;
        done_next = done_reg && !write_done_clear_i;
        ee_we = 1'b0;
        pm_we = 1'b0;
        ee_wdata = data_lo_reg;
        pm_wdata = `NVM_ERASED_WORD;
        pm_maddr = pm_addr;
        latch_load = 1'b0;
        latch_clear = 1'b0;
        rd_pend_next = ctl_reg[`NVM_CTL_RD] && !rd_pend_reg;
        if (reg_wr_i) begin
            case (reg_sel_i)
                `NVM_SEL_ADDR_LOW: addr_lo_next = reg_wdata_i;
                `NVM_SEL_ADDR_HIGH: addr_hi_next = reg_wdata_i[6:0];
                `NVM_SEL_DATA_LOW: data_lo_next = reg_wdata_i;
                `NVM_SEL_DATA_HIGH: data_hi_next = reg_wdata_i[5:0];
                `NVM_SEL_CONTROL: begin
                    // Writing zero to a strobe does nothing; hardware alone clears it.
                    ctl_next = reg_wdata_i;
                    ctl_next[`NVM_CTL_RD] = ctl_reg[`NVM_CTL_RD]
                        || (reg_wdata_i[`NVM_CTL_RD] && st_reg == ST_IDLE);
                    ctl_next[`NVM_CTL_WR] = ctl_reg[`NVM_CTL_WR] || start;
                end
                default: ;
            endcase
        end
        // Read data lands one cycle after the array is strobed.
        if (rd_pend_reg) begin
            ctl_next[`NVM_CTL_RD] = 1'b0;
            if (ctl_reg[`NVM_CTL_CONFIG_SPACE_SELECT]) begin
                data_lo_next = 8'h00;
                data_hi_next = 6'h00;
            end else if (ctl_reg[`NVM_CTL_PGD]) begin
                data_lo_next = pm_q[7:0];
                data_hi_next = pm_q[13:8];
            end else begin
                data_lo_next = ee_q;
            end
        end
        case (st_reg)
            ST_IDLE: begin
                if (start) begin
                    op_pm_next = reg_wdata_i[`NVM_CTL_PGD];
                    op_erase_next = reg_wdata_i[`NVM_CTL_FREE];
                    op_quiet_next = 1'b0;
                    cnt_next = 24'h00_0000;
                    if (reg_wdata_i[`NVM_CTL_CONFIG_SPACE_SELECT]) begin
                        st_next = ST_FINISH;
                    end else if (!reg_wdata_i[`NVM_CTL_PGD]) begin
                        st_next = ST_WAIT;
                    end else if (pm_locked) begin
                        st_next = ST_FINISH;
                    end else if (reg_wdata_i[`NVM_CTL_FREE]) begin
                        st_next = ST_WAIT;
                    end else begin
                        latch_load = 1'b1;
                        op_quiet_next = reg_wdata_i[`NVM_CTL_LATCH_LOAD_ONLY];
                        st_next = reg_wdata_i[`NVM_CTL_LATCH_LOAD_ONLY] ? ST_FINISH : ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                cnt_next = cnt_reg + 24'h00_0001;
                if (cnt_reg == 24'(WRITE_CYCLES - 1)) begin
                    cnt_next = 24'h00_0000;
                    if (!op_pm_reg) begin
                        st_next = ST_EE_ERASE;
                    end else if (op_erase_reg) begin
                        st_next = ST_PM_ROW;
                    end else begin
                        st_next = ST_PM_BLOCK;
                    end
                end
            end
            ST_EE_ERASE: begin
                ee_we = 1'b1;
                ee_wdata = `NVM_ERASED_BYTE;
                st_next = ST_EE_PROG;
            end
            ST_EE_PROG: begin
                ee_we = 1'b1;
                st_next = ST_FINISH;
            end
            ST_PM_ROW: begin
                pm_we = 1'b1;
                pm_maddr = {pm_addr[14:5], cnt_reg[4:0]};
                cnt_next = cnt_reg + 24'h00_0001;
                if (cnt_reg == `NVM_ROW_LAST) begin
                    st_next = ST_FINISH;
                end
            end
            ST_PM_BLOCK: begin
                pm_we = 1'b1;
                pm_maddr = {pm_addr[14:3], cnt_reg[2:0]};
                pm_wdata = latch_q[cnt_reg[2:0]];
                cnt_next = cnt_reg + 24'h00_0001;
                if (cnt_reg == `NVM_LATCH_LAST) begin
                    latch_clear = 1'b1;
                    st_next = ST_FINISH;
                end
            end
            ST_FINISH: begin
                ctl_next[`NVM_CTL_WR] = 1'b0;
                done_next = done_reg || !op_quiet_reg;
                st_next = ST_IDLE;
            end
            default: st_next = ST_IDLE;
        endcase
        // A plain reset keeps write enable and flags an interrupted write.
        if (reset_i) begin
            ctl_next = `NVM_CTL_RESET;
            ctl_next[`NVM_CTL_WRITE_ENABLE_BIT] = ctl_reg[`NVM_CTL_WRITE_ENABLE_BIT] && !power_up_i;
            ctl_next[`NVM_CTL_WRITE_ERROR_FLAG] = !power_up_i
                && (ctl_reg[`NVM_CTL_WRITE_ERROR_FLAG] || st_reg != ST_IDLE);
            addr_lo_next = 8'h00;
            addr_hi_next = 7'h00;
            data_lo_next = 8'h00;
            data_hi_next = 6'h00;
            st_next = ST_IDLE;
            cnt_next = 24'h00_0000;
            rd_pend_next = 1'b0;
            done_next = 1'b0;
            op_pm_next = 1'b0;
            op_erase_next = 1'b0;
            op_quiet_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        ctl_reg <= ctl_next;
        addr_lo_reg <= addr_lo_next;
        addr_hi_reg <= addr_hi_next;
        data_lo_reg <= data_lo_next;
        data_hi_reg <= data_hi_next;
        st_reg <= st_next;
        cnt_reg <= cnt_next;
        rd_pend_reg <= rd_pend_next;
        done_reg <= done_next;
        op_pm_reg <= op_pm_next;
        op_erase_reg <= op_erase_next;
        op_quiet_reg <= op_quiet_next;
        lock_dat_reg <= lock_dat_next;
        lock_code_reg <= lock_code_next;
        unlock_rd_reg <= 8'h00;
    end

    // ****************************************************************
    // Write latches
    // ****************************************************************
    for (genvar i = 0; i < 8; i++) begin : g_latch
        logic [13:0] l_reg, l_next;
        always_comb begin
            l_next = l_reg;
            if (latch_load && pm_addr[2:0] == 3'(i)) begin
                l_next = {data_hi_reg, data_lo_reg};
            end
            if (latch_clear || reset_i) begin
                l_next = `NVM_ERASED_WORD;
            end
        end
        always_ff @(posedge mclk_i) begin
            l_reg <= l_next;
        end
        assign latch_q[i] = l_reg;
    end

    // ****************************************************************
    // Arrays and power-up timer
    // ****************************************************************
    assign ee_re = rd_pend_next && !ctl_reg[`NVM_CTL_PGD];
    assign pm_re = rd_pend_next && ctl_reg[`NVM_CTL_PGD];
    nvm_array #(.WIDTH(8), .AWIDTH(8)) u_eeprom (
        .mclk_i(mclk_i), .we_i(ee_we), .re_i(ee_re), .addr_i(addr_lo_reg),
        .wdata_i(ee_wdata), .rdata_o(ee_q)
    );
    nvm_array #(.WIDTH(14), .AWIDTH(15)) u_program (
        .mclk_i(mclk_i), .we_i(pm_we), .re_i(pm_re), .addr_i(pm_maddr),
        .wdata_i(pm_wdata), .rdata_o(pm_q)
    );
    startup_timer #(.CYCLES(PWRT_CYCLES)) u_pwrt (
        .mclk_i(mclk_i), .reset_i(reset_i), .power_up_i(power_up_i),
        .running_o(pwrt_running)
    );
    assign nvm_control_o = ctl_reg;
    assign nvm_unlock_o = unlock_rd_reg;
    assign nvm_addr_low_o = addr_lo_reg;
    assign nvm_addr_high_o = {1'b0, addr_hi_reg};
    assign nvm_data_low_o = data_lo_reg;
    assign nvm_data_high_o = {2'b00, data_hi_reg};
    assign write_done_flag_o = done_reg;
    assign prog_port_data_lock_o = lock_dat_reg;
    assign prog_port_code_lock_o = lock_code_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    unlock_reads_zero_a: assert property (nvm_unlock_o == 8'h00)
        else $error("unlock register read nonzero");
    write_enable_bit_kept_a: assert property ($fell(ctl_reg[`NVM_CTL_WRITE_ENABLE_BIT]) |-> $past(ctl_write))
        else $error("write enable cleared by hardware");
    wr_needs_write_enable_bit_a: assert property ($rose(ctl_reg[`NVM_CTL_WR]) |-> $past(ctl_reg[`NVM_CTL_WRITE_ENABLE_BIT]))
        else $error("write strobe set without write enable");
    wr_needs_key_a: assert property ($rose(ctl_reg[`NVM_CTL_WR]) |-> $past(ul_reg) == UL_ARMED)
        else $error("write started without unlock keys");
    pwrt_blocks_a: assert property ($rose(ctl_reg[`NVM_CTL_WR]) |-> !$past(pwrt_running))
        else $error("write started while power-up timer ran");
    read_two_cycles_a: assert property ($rose(ctl_reg[`NVM_CTL_RD]) |=> ctl_reg[`NVM_CTL_RD] ##1 !ctl_reg[`NVM_CTL_RD])
        else $error("read strobe did not clear after two cycles");
    done_on_end_a: assert property (st_reg == ST_FINISH && !op_quiet_reg && !write_done_clear_i
        |=> !ctl_reg[`NVM_CTL_WR] && done_reg)
        else $error("write end did not clear strobe and set flag");
    latches_reset_a: assert property (latch_clear |=> latch_q[0] == `NVM_ERASED_WORD
        && latch_q[7] == `NVM_ERASED_WORD)
        else $error("write latches not reset after program write");
    ee_erase_first_a: assert property (st_reg == ST_EE_ERASE |-> ee_we
        && ee_wdata == `NVM_ERASED_BYTE ##1 ee_we && ee_wdata == data_lo_reg)
        else $error("EEPROM byte not erased before program");
    reset_error_a: assert property (@(posedge mclk_i) disable iff (power_up_i)
        reset_i && st_reg != ST_IDLE |=> ctl_reg[`NVM_CTL_WRITE_ERROR_FLAG])
        else $error("interrupted write did not flag error");
endmodule : eeprom_flash_access_ctrl

/* tb/eeprom_flash_access_ctrl_tb_top.sv */
`timescale 1ns/100ps
module eeprom_flash_access_ctrl_tb_top;
    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam int PWRT = 20;
    localparam int WRT = 10;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic power_up_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic write_done_clear_i = 1'b0;
    logic [2:0] reg_sel_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [1:0] self_write_protect_i = 2'h3;
    logic data_protect_bit_i = 1'b1;
    logic code_protect_i = 1'b1;
    logic [7:0] ctl, unl, adl, adh, dtl, dth;
    logic done, dlock, clock;
    int errors = 0;
    int n_tests = 0;
    logic [7:0] ee_model [256];
    logic [7:0] addrs [6];
    logic [7:0] a, d;

    eeprom_flash_access_ctrl #(.PWRT_CYCLES(PWRT), .WRITE_CYCLES(WRT)) uut (
        .mclk_i(mclk_i), .reset_i(reset_i), .power_up_i(power_up_i),
        .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i),
        .write_done_clear_i(write_done_clear_i),
        .self_write_protect_i(self_write_protect_i),
        .data_protect_bit_i(data_protect_bit_i), .code_protect_i(code_protect_i),
        .nvm_control_o(ctl), .nvm_unlock_o(unl), .nvm_addr_low_o(adl),
        .nvm_addr_high_o(adh), .nvm_data_low_o(dtl), .nvm_data_high_o(dth),
        .write_done_flag_o(done), .prog_port_data_lock_o(dlock),
        .prog_port_code_lock_o(clock)
    );

    initial begin
        forever #4 mclk_i = ~mclk_i;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    function automatic logic [7:0] exp_read(input logic [7:0] addr);
        return ee_model[addr];
    endfunction : exp_read

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_test(input string name);
        $display("Test %s done", name);
    endtask : end_test

    task automatic reg_write(input logic [2:0] sel, input logic [7:0] val);
        @(negedge mclk_i);
        reg_wr_i = 1'b1;
        reg_sel_i = sel;
        reg_wdata_i = val;
        @(negedge mclk_i);
        reg_wr_i = 1'b0;
    endtask : reg_write

    task automatic unlock_start(input logic [7:0] ctl_val);
        reg_write(3'h5, 8'h55);
        reg_write(3'h5, 8'hAA);
        reg_write(3'h4, ctl_val);
    endtask : unlock_start

    // The wait is bounded so a write that never ends shows as a mismatch.
    task automatic wait_done(input int limit);
        int i;
        for (i = 0; i < limit; i++) begin
            if (done === 1'b1) break;
            @(negedge mclk_i);
        end
    endtask : wait_done

    task automatic clear_flag();
        @(negedge mclk_i);
        write_done_clear_i = 1'b1;
        @(negedge mclk_i);
        write_done_clear_i = 1'b0;
    endtask : clear_flag

    task automatic ee_write(input logic [7:0] addr, input logic [7:0] val);
        reg_write(3'h0, addr);
        reg_write(3'h2, val);
        reg_write(3'h4, 8'h04);
        unlock_start(8'h06);
        ee_model[addr] = val;
        check(ctl[1], 1'b1);
        check(unl, 8'h00);
        // Dropping write enable mid-write must not cut the write short.
        reg_write(3'h4, 8'h00);
        check(ctl[1], 1'b1);
        wait_done(WRT + 20);
        check(done, 1'b1);
        check(ctl[1], 1'b0);
        clear_flag();
        check(done, 1'b0);
    endtask : ee_write

    task automatic ee_read(input logic [7:0] addr);
        reg_write(3'h0, addr);
        reg_write(3'h4, 8'h01);
        repeat (4) @(negedge mclk_i);
        check(ctl[0], 1'b0);
        check(adl, addr);
    endtask : ee_read

    task automatic pm_load(input logic [7:0] lo, input logic [13:0] w, input logic [7:0] c);
        reg_write(3'h0, lo);
        reg_write(3'h2, w[7:0]);
        reg_write(3'h3, {2'b00, w[13:8]});
        reg_write(3'h4, c);
        unlock_start(c | 8'h02);
    endtask : pm_load

    task automatic pm_read(input logic [7:0] lo, input logic [15:0] exp);
        reg_write(3'h0, lo);
        reg_write(3'h4, 8'h81);
        repeat (4) @(negedge mclk_i);
        check(ctl[0], 1'b0);
        check({dth, dtl}, exp);
    endtask : pm_read

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #100_000;
        errors++;
        report_and_stop();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        void'($urandom(42));
        repeat (5) @(negedge mclk_i);
        reset_i = 1'b0;
        power_up_i = 1'b0;
        check(ctl, 8'h00);
        check(unl, 8'h00);
        check(done, 1'b0);
        end_test("reset");
        reg_write(3'h4, 8'h04);
        unlock_start(8'h06);
        check(ctl[1], 1'b0);
        end_test("startup lock");
        repeat (PWRT + 5) @(negedge mclk_i);
        reg_write(3'h4, 8'h00);
        unlock_start(8'h02);
        check(ctl[1], 1'b0);
        reg_write(3'h4, 8'h04);
        reg_write(3'h5, 8'h55);
        reg_write(3'h0, 8'h10);
        reg_write(3'h5, 8'hAA);
        reg_write(3'h4, 8'h06);
        check(ctl[1], 1'b0);
        end_test("refused starts");
        // Zero then a mixed value at one address needs the automatic erase.
        for (int i = 0; i < 6; i++) begin
            a = (i == 1) ? 8'hFF : (i < 3) ? 8'h00 : 8'($urandom);
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 2) ? 8'hA5 : 8'($urandom);
            addrs[i] = a;
            ee_write(a, d);
        end
        end_test("byte writes");
        data_protect_bit_i = 1'b0;
        for (int i = 0; i < 6; i++) begin
            ee_read(addrs[i]);
            check(dtl, exp_read(addrs[i]));
        end
        repeat (8) @(negedge mclk_i);
        check(dtl, exp_read(addrs[5]));
        reg_write(3'h2, 8'h5A);
        check(dtl, 8'h5A);
        end_test("readback");
        reg_write(3'h0, 8'h33);
        reg_write(3'h2, 8'hC3);
        reg_write(3'h4, 8'h04);
        unlock_start(8'h06);
        repeat (3) @(negedge mclk_i);
        reset_i = 1'b1;
        @(negedge mclk_i);
        reset_i = 1'b0;
        check(ctl[3], 1'b1);
        check(ctl[2], 1'b1);
        check(ctl[1], 1'b0);
        reg_write(3'h4, 8'h00);
        end_test("reset mid write");
        // Erase a row, then show that a protected write leaves it erased.
        reg_write(3'h1, 8'hFF);
        check(adh, 8'h7F);
        reg_write(3'h0, 8'h20);
        reg_write(3'h4, 8'h94);
        unlock_start(8'h96);
        wait_done(WRT + 50);
        check(done, 1'b1);
        clear_flag();
        pm_read(8'h3F, 16'h3FFF);
        self_write_protect_i = 2'h0;
        pm_load(8'h3F, 14'h0000, 8'h84);
        wait_done(10);
        check(done, 1'b1);
        check(ctl[1], 1'b0);
        clear_flag();
        pm_read(8'h3F, 16'h3FFF);
        check(dth[7:6], 2'h0);
        // A latch-only load raises no flag; the next load writes the whole block.
        self_write_protect_i = 2'h3;
        pm_load(8'h38, 14'h0155, 8'hA4);
        repeat (4) @(negedge mclk_i);
        check(done, 1'b0);
        check(ctl[1], 1'b0);
        pm_load(8'h3F, 14'h1234, 8'h84);
        wait_done(WRT + 20);
        check(done, 1'b1);
        clear_flag();
        pm_read(8'h38, 16'h0155);
        pm_read(8'h39, 16'h3FFF);
        pm_read(8'h3F, 16'h1234);
        end_test("program space");
        for (int i = 0; i < 4; i++) begin
            data_protect_bit_i = i[0];
            code_protect_i = i[1];
            repeat (2) @(negedge mclk_i);
            check(dlock, !data_protect_bit_i);
            check(clock, !code_protect_i);
        end
        end_test("protection locks");
        report_and_stop();
    end
endmodule : eeprom_flash_access_ctrl_tb_top
